// ---- verilog/bsc_top.sv ----
// boot strap capture with axi4-lite register access
//
// Local design decisions: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_top
    import bsc_pkg::*;
(
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // board pins
    input  wire logic                   global_reset_n,
    input  wire logic                   global_clk_freq_strap,
    input  wire logic [2:0]             port_clocking_strap,
    input  wire logic [3:0]             eeprom_bus_addr_strap,
    input  wire logic                   master_bus_slow_strap,
    input  wire logic [7:0]             pair_join_strap,
    input  wire logic                   reset_hold,
    input  wire logic [3:0]             slave_bus_addr_strap,
    input  wire logic [3:0]             switch_op_select,
    // eeprom loader
    input  wire logic                   eeprom_load_err,
    output logic                        eeprom_load_abort,
    // core configuration
    output logic                        core_reset_n,
    output logic                        master_bus_en,
    output logic                        slave_bus_en,
    output logic                        global_clk_freq_sel,
    output logic [2:0]                  port_clock_mode,
    output logic [3:0]                  eeprom_bus_addr,
    output logic [7:0]                  master_bus_prescaler,
    output logic [7:0]                  pair_join,
    output logic [3:0]                  slave_bus_addr,
    output logic [3:0]                  switch_mode,
    // axi4-lite write address
    input  wire logic                   awvalid,
    output logic                        awready,
    input  wire logic [`BSC_ADDR_W-1:0] awaddr,
    input  wire logic [2:0]             awprot,
    // axi4-lite write data
    input  wire logic                   wvalid,
    output logic                        wready,
    input  wire logic [31:0]            wdata,
    input  wire logic [3:0]             wstrb,
    // axi4-lite write response
    output logic                        bvalid,
    input  wire logic                   bready,
    output logic [1:0]                  bresp,
    // axi4-lite read address
    input  wire logic                   arvalid,
    output logic                        arready,
    input  wire logic [`BSC_ADDR_W-1:0] araddr,
    input  wire logic [2:0]             arprot,
    // axi4-lite read data
    output logic                        rvalid,
    input  wire logic                   rready,
    output logic [31:0]                 rdata,
    output logic [1:0]                  rresp
);
    logic [`BSC_VEC_W-1:0] strap_pins;
    logic [`BSC_VEC_W-1:0] strap_s;
    logic                  rst_s;
    logic                  rst_rise;
    logic                  wr_go;
    logic [32:0]           rd_word;
    bsc_st_t               r;
    bsc_st_t               n;

    assign strap_pins = {switch_op_select, slave_bus_addr_strap, reset_hold,
                         pair_join_strap, master_bus_slow_strap,
                         eeprom_bus_addr_strap, port_clocking_strap,
                         global_clk_freq_strap};

    // straps are synchronised too so a strap moving at the reset edge
    // cannot be caught half old, half new
    bsc_sync #(.W(`BSC_VEC_W)) u_strap_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (strap_pins),
        .dout    (strap_s)
    );

    bsc_sync #(.W(1)) u_rst_sync (
        .aclk    (aclk),
        .aresetn (aresetn),
        .din     (global_reset_n),
        .dout    (rst_s)
    );

    // read decode; unmapped offsets answer with an error and zero data
    function automatic logic [32:0] rd_mux(input logic [`BSC_ADDR_W-1:0] a,
                                           input bsc_st_t s);
        logic [32:0] v;
        v = {1'b1, 32'h0000_0000};
        case (a)
            `BSC_OFS_STATUS: v = {1'b0, 6'h00, s.status};
            `BSC_OFS_PCLK:   v = {1'b0, 29'h0000_0000, s.pclk};
            `BSC_OFS_BUSCTL: v = {1'b0, 24'h00_0000, s.presc};
            `BSC_OFS_SWITCH_CONTROL_REG:  v = {1'b0, 31'h0000_0000, s.hold};
            `BSC_OFS_RUNSTS: v = {1'b0, 30'h0000_0000, s.state};
            default:         v = {1'b1, 32'h0000_0000};
        endcase
        return v;
    endfunction

    assign awready  = ~r.aw_have & ~r.bvalid;
    assign wready   = ~r.w_have & ~r.bvalid;
    assign arready  = ~r.rvalid;
    assign rst_rise = rst_s & ~r.rst_seen;
    assign wr_go    = r.aw_have & r.w_have & ~r.bvalid;
    assign rd_word  = rd_mux(araddr, r);

    always_comb begin
        n          = r;
        n.abort    = 1'b0;
        n.rst_seen = rst_s;

        // register slave stays live in every state, halt included
        if (awvalid && awready) begin
            n.aw_have = 1'b1;
            n.awaddr  = awaddr;
        end
        if (wvalid && wready) begin
            n.w_have = 1'b1;
            n.wdata  = wdata;
            n.wstrb  = wstrb;
        end
        if (r.bvalid && bready) begin
            n.bvalid = 1'b0;
        end
        if (wr_go) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = `BSC_RESP_OKAY;
            case (r.awaddr)
                `BSC_OFS_STATUS: begin
                end
                `BSC_OFS_RUNSTS: begin
                end
                `BSC_OFS_PCLK: begin
                    if (r.wstrb[0]) begin
                        n.pclk = r.wdata[2:0];
                    end
                end
                `BSC_OFS_BUSCTL: begin
                    if (r.wstrb[0]) begin
                        n.presc = r.wdata[7:0];
                    end
                end
                `BSC_OFS_SWITCH_CONTROL_REG: begin
                    if (r.wstrb[0]) begin
                        n.hold = r.wdata[`BSC_SWITCH_CONTROL_REG_HOLD];
                    end
                end
                default: begin
                    n.bresp = `BSC_RESP_SLVERR;
                end
            endcase
        end
        if (r.rvalid && rready) begin
            n.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            n.rvalid = 1'b1;
            n.rdata  = rd_word[31:0];
            n.rresp  = rd_word[32] ? `BSC_RESP_SLVERR : `BSC_RESP_OKAY;
        end

        // capture on negation of the reset pin; nothing else writes status
        if (!rst_s) begin
            n.state = bsc_st_reset;
        end else if (rst_rise) begin
            n.status = strap_s;
            n.pclk   = strap_s[`BSC_F_PCLK_HI:`BSC_F_PCLK_LO];
            n.presc  = strap_s[`BSC_F_SLOW] ? `BSC_PRESC_SLOW
                                             : `BSC_PRESC_FAST;
            n.hold   = strap_s[`BSC_F_HOLD];
            n.state  = strap_s[`BSC_F_HOLD] ? bsc_st_halt
                                             : bsc_st_run;
        end else begin
            case (r.state)
                bsc_st_halt: begin
                    if (!r.hold) begin
                        n.state = bsc_st_run;
                    end
                end
                bsc_st_run: begin
                    if (r.hold) begin
                        n.state = bsc_st_halt;
                    end
                end
                default: begin
                    n.state = bsc_st_reset;
                end
            endcase
        end

        // a load error wins over a software clear in the same cycle
        if (eeprom_load_err && rst_s && !rst_rise &&
            r.state != bsc_st_reset) begin
            n.hold  = 1'b1;
            n.abort = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    // held state keeps the core in reset but both buses running
    assign core_reset_n         = (r.state == bsc_st_run);
    assign master_bus_en        = (r.state != bsc_st_reset);
    assign slave_bus_en         = (r.state != bsc_st_reset);
    assign eeprom_load_abort    = r.abort;
    assign global_clk_freq_sel  = r.status[`BSC_F_GCLK];
    assign port_clock_mode      = r.pclk;
    // never writable: straight from the latch
    assign eeprom_bus_addr      = r.status[`BSC_F_EADDR_HI:`BSC_F_EADDR_LO];
    assign master_bus_prescaler = r.presc;
    assign pair_join            = r.status[`BSC_F_JOIN_HI:`BSC_F_JOIN_LO];
    assign slave_bus_addr       = r.status[`BSC_F_SADDR_HI:`BSC_F_SADDR_LO];
    assign switch_mode          = r.status[`BSC_F_MODE_HI:`BSC_F_MODE_LO];
    assign bvalid               = r.bvalid;
    assign bresp                = r.bresp;
    assign rvalid               = r.rvalid;
    assign rdata                = r.rdata;
    assign rresp                = r.rresp;

    property p_capture;
        @(posedge aclk) disable iff (!aresetn)
        rst_rise |=> (r.status == $past(strap_s));
    endproperty
    a_capture: assert property (p_capture)
        else $error("straps not latched at reset release");

    property p_ignore;
        @(posedge aclk) disable iff (!aresetn)
        !rst_rise |=> $stable(r.status);
    endproperty
    a_ignore: assert property (p_ignore)
        else $error("status changed outside reset release");

    property p_halt_entry;
        @(posedge aclk) disable iff (!aresetn)
        rst_rise && strap_s[`BSC_F_HOLD] |=>
            (r.state == bsc_st_halt) && !core_reset_n &&
            master_bus_en && slave_bus_en;
    endproperty
    a_halt_entry: assert property (p_halt_entry)
        else $error("hold strap did not halt with buses active");

    property p_halt_exit;
        @(posedge aclk) disable iff (!aresetn)
        (r.state == bsc_st_halt) && rst_s && !rst_rise && !r.hold
            |=> core_reset_n;
    endproperty
    a_halt_exit: assert property (p_halt_exit)
        else $error("halt not left after hold cleared");

    property p_halt_stay;
        @(posedge aclk) disable iff (!aresetn)
        (r.state == bsc_st_halt) && r.hold && rst_s |=> !core_reset_n;
    endproperty
    a_halt_stay: assert property (p_halt_stay)
        else $error("halt left while hold still set");

    property p_load_err;
        @(posedge aclk) disable iff (!aresetn)
        eeprom_load_err && rst_s && !rst_rise && (r.state != bsc_st_reset)
            |=> r.hold && eeprom_load_abort ##1 !core_reset_n;
    endproperty
    a_load_err: assert property (p_load_err)
        else $error("load error did not set hold");

    property p_seed;
        @(posedge aclk) disable iff (!aresetn)
        rst_rise |=> (port_clock_mode ==
                      $past(strap_s[`BSC_F_PCLK_HI:`BSC_F_PCLK_LO])) &&
                     (master_bus_prescaler == ($past(strap_s[`BSC_F_SLOW])
                      ? `BSC_PRESC_SLOW : `BSC_PRESC_FAST));
    endproperty
    a_seed: assert property (p_seed)
        else $error("overridable fields not seeded from straps");

    property p_fixed;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && !rst_rise |=> $stable(global_clk_freq_sel) &&
            $stable(eeprom_bus_addr) && $stable(pair_join) &&
            $stable(slave_bus_addr) && $stable(switch_mode);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("fixed strap value changed by a write");

    property p_read_status;
        @(posedge aclk) disable iff (!aresetn)
        arvalid && arready && (araddr == `BSC_OFS_STATUS) && !rst_rise
            |=> rvalid && (rdata[`BSC_VEC_W-1:0] == $past(r.status));
    endproperty
    a_read_status: assert property (p_read_status)
        else $error("status read does not show latched straps");

    property p_wr_resp;
        @(posedge aclk) disable iff (!aresetn)
        wr_go |=> bvalid;
    endproperty
    a_wr_resp: assert property (p_wr_resp)
        else $error("write response missing");

    property p_b_hold;
        @(posedge aclk) disable iff (!aresetn)
        bvalid && !bready |=> bvalid && $stable(bresp);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write response dropped before bready");

    property p_r_hold;
        @(posedge aclk) disable iff (!aresetn)
        rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read data dropped before rready");

    property p_aw_refuse;
        @(posedge aclk) disable iff (!aresetn)
        bvalid |-> !awready && !wready;
    endproperty
    a_aw_refuse: assert property (p_aw_refuse)
        else $error("new write taken while response pending");

    property p_bus_off;
        @(posedge aclk) disable iff (!aresetn)
        !rst_s |=> !core_reset_n && !master_bus_en && !slave_bus_en;
    endproperty
    a_bus_off: assert property (p_bus_off)
        else $error("device not in reset while reset pin low");

    property p_hold_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && (r.awaddr == `BSC_OFS_SWITCH_CONTROL_REG) && r.wstrb[0] &&
            !rst_rise && !eeprom_load_err
            |=> (r.hold == $past(r.wdata[`BSC_SWITCH_CONTROL_REG_HOLD]));
    endproperty
    a_hold_write: assert property (p_hold_write)
        else $error("hold bit write did not land");

    property p_pclk_write;
        @(posedge aclk) disable iff (!aresetn)
        wr_go && (r.awaddr == `BSC_OFS_PCLK) && r.wstrb[0] && !rst_rise
            |=> (port_clock_mode == $past(r.wdata[2:0]));
    endproperty
    a_pclk_write: assert property (p_pclk_write)
        else $error("port clocking write did not override strap");
endmodule
`default_nettype wire

// ---- verilog/bsc_consts.svh ----
// constants of the boot strap capture block
// Functional notes
// - latch every strap input during a switch fundamental reset only.
// - strap changes outside that reset have no effect on operation.
// - a readable status register shows every strap latched at last reset.
// - clock frequency strap sets reference clock frequency; never overridden.
// - four-bit strap gives eeprom bus address bits 4 to 1; fixed.
// - slow strap sets master bus speed; prescaler field writes override it.
// - eight join straps merge port pairs 0/1 through 14/15; fixed.
// - hold strap keeps device in reset with both buses active.
// - while held in reset, register reads and writes are accepted.
// - leave the held state only when the hold bit is cleared.
// - four-bit strap gives slave address bits 5,3,2,1; fixed.
// - four-bit strap selects switch operating mode; fixed.
// - further setup comes over the slave bus or from the eeprom.
// - latching happens when the global reset input is negated.
// - eeprom load error aborts the load and sets the hold bit.
`ifndef BSC_CONSTS_SVH
`define BSC_CONSTS_SVH

`define BSC_VEC_W        26
`define BSC_F_GCLK       0
`define BSC_F_PCLK_LO    1
`define BSC_F_PCLK_HI    3
`define BSC_F_EADDR_LO   4
`define BSC_F_EADDR_HI   7
`define BSC_F_SLOW       8
`define BSC_F_JOIN_LO    9
`define BSC_F_JOIN_HI    16
`define BSC_F_HOLD       17
`define BSC_F_SADDR_LO   18
`define BSC_F_SADDR_HI   21
`define BSC_F_MODE_LO    22
`define BSC_F_MODE_HI    25

`define BSC_ADDR_W       8
`define BSC_OFS_STATUS   8'h00
`define BSC_OFS_PCLK     8'h04
`define BSC_OFS_BUSCTL   8'h08
`define BSC_OFS_SWITCH_CONTROL_REG    8'h0C
`define BSC_OFS_RUNSTS   8'h10

`define BSC_PRESC_FAST   8'h0A
`define BSC_PRESC_SLOW   8'h28
`define BSC_SWITCH_CONTROL_REG_HOLD   0

`define BSC_RESP_OKAY    2'h0
`define BSC_RESP_SLVERR  2'h2

`endif

// ---- verilog/bsc_pkg.sv ----
// types of the boot strap capture block
`include "bsc_consts.svh"
package bsc_pkg;
    typedef enum logic [1:0] {
        bsc_st_reset = 2'b00,
        bsc_st_halt  = 2'b01,
        bsc_st_run   = 2'b10
    } bsc_state_t;

    typedef struct packed {
        bsc_state_t                state;
        logic                      rst_seen;
        logic [`BSC_VEC_W-1:0]     status;
        logic [2:0]                pclk;
        logic [7:0]                presc;
        logic                      hold;
        logic                      abort;
        logic                      aw_have;
        logic [`BSC_ADDR_W-1:0]    awaddr;
        logic                      w_have;
        logic [31:0]               wdata;
        logic [3:0]                wstrb;
        logic                      bvalid;
        logic [1:0]                bresp;
        logic                      rvalid;
        logic [31:0]               rdata;
        logic [1:0]                rresp;
    } bsc_st_t;
endpackage

// ---- verilog/bsc_sync.sv ----
// three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module bsc_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         aclk,
    input  wire logic         aresetn,
    // pins and filtered result
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] q;
    } bsc_sync_st_t;

    bsc_sync_st_t r;
    bsc_sync_st_t n;

    always_comb begin
        n    = r;
        n.s1 = din;
        n.s2 = r.s1;
        n.s3 = r.s2;
        // a bit changes only once the second and third stages agree
        for (int i = 0; i < W; i++) begin
            if (r.s2[i] == r.s3[i]) begin
                n.q[i] = r.s3[i];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign dout = r.q;
endmodule
`default_nettype wire

// ---- verif/bsc_board.sv ----
// board-side model: strap pins, global reset pin and eeprom loader error
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.svh"
module bsc_board (
    // clock
    input  wire logic                  aclk,
    // board pins
    output logic                       global_reset_n,
    output logic [`BSC_VEC_W-1:0]      strap_vec,
    // eeprom loader
    output logic                       eeprom_load_err
);
    initial begin
        global_reset_n  = 1'b0;
        strap_vec       = '0;
        eeprom_load_err = 1'b0;
    end
    // straps are set while the reset pin is low, as a board does
    task automatic press(input logic [`BSC_VEC_W-1:0] v);
        @(posedge aclk);
        strap_vec      <= v;
        global_reset_n <= 1'b0;
    endtask
    // straps stay put well past release, so the sampled value is defined
    task automatic release_pin();
        @(posedge aclk);
        global_reset_n <= 1'b1;
        repeat (10) @(posedge aclk);
    endtask
    task automatic wiggle(input logic [`BSC_VEC_W-1:0] v);
        @(posedge aclk);
        strap_vec <= v;
    endtask
    // a failed eeprom load, reported for one cycle
    task automatic load_error();
        @(posedge aclk);
        eeprom_load_err <= 1'b1;
        @(posedge aclk);
        eeprom_load_err <= 1'b0;
    endtask
endmodule
`default_nettype wire

// ---- verif/boot_strap_capture_tb_top.sv ----
// self-checking bench of the boot strap capture block
`timescale 1ns/1ps
`default_nettype none
`include "bsc_consts.svh"
module boot_strap_capture_tb_top;
    logic        aclk = 1'b0, aresetn = 1'b0;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        global_reset_n, err, abort_o, core_reset_n, mben, sben;
    logic        gsel;
    logic [`BSC_VEC_W-1:0] sv;
    logic [2:0]  pcm;
    logic [3:0]  eba, sba, swm;
    logic [7:0]  presc, pj;
    int          n_mismatch = 0;
    int          checks = 0;

    always #12.5 aclk = ~aclk;

    bsc_board bsc_board_i (.aclk(aclk), .global_reset_n(global_reset_n),
        .strap_vec(sv), .eeprom_load_err(err));

    bsc_top bsc_top_i (
        .aclk(aclk), .aresetn(aresetn), .global_reset_n(global_reset_n),
        .global_clk_freq_strap(sv[0]), .port_clocking_strap(sv[3:1]),
        .eeprom_bus_addr_strap(sv[7:4]), .master_bus_slow_strap(sv[8]),
        .pair_join_strap(sv[16:9]), .reset_hold(sv[17]),
        .slave_bus_addr_strap(sv[21:18]), .switch_op_select(sv[25:22]),
        .eeprom_load_err(err), .eeprom_load_abort(abort_o),
        .core_reset_n(core_reset_n), .master_bus_en(mben),
        .slave_bus_en(sben), .global_clk_freq_sel(gsel),
        .port_clock_mode(pcm), .eeprom_bus_addr(eba),
        .master_bus_prescaler(presc), .pair_join(pj),
        .slave_bus_addr(sba), .switch_mode(swm),
        .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
        .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
        .arvalid(arvalid), .arready(arready), .araddr(araddr),
        .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [7:0] exp_presc(input logic slow);
        return slow ? `BSC_PRESC_SLOW : `BSC_PRESC_FAST;
    endfunction

    task automatic end_of_test();
        if (n_mismatch == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask
    // one write; address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awvalid <= 1'b1;
        awaddr  <= a;
        wvalid  <= 1'b1;
        wdata   <= d;
        wstrb   <= 4'hF;
        bready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready) && n < 100);
        chk(32'(bresp), 32'(er));
        bready <= 1'b0;
        if (n >= 100) n_mismatch++;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        arvalid <= 1'b1;
        araddr  <= a;
        rready  <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready) && n < 100);
        chk(rdata, e);
        chk(32'(rresp), 32'(er));
        rready <= 1'b0;
        if (n >= 100) n_mismatch++;
    endtask
    task automatic chk_out(input logic [`BSC_VEC_W-1:0] v);
        chk(32'(gsel), 32'(v[0]));
        chk(32'(eba), 32'(v[7:4]));
        chk(32'(pj), 32'(v[16:9]));
        chk(32'(sba), 32'(v[21:18]));
        chk(32'(swm), 32'(v[25:22]));
    endtask

    initial begin
        repeat (5000) @(posedge aclk);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        logic [31:0] lf;
        logic [`BSC_VEC_W-1:0] v;
        int na;
        lf = 32'hBC83;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 6; i++) begin
            lf = lfsr(lf);
            v = lf[`BSC_VEC_W-1:0];
            v[`BSC_F_HOLD] = i[0];
            bsc_board_i.press(v);
            repeat (8) @(posedge aclk);
            rd(`BSC_OFS_RUNSTS, 32'h0, `BSC_RESP_OKAY);
            chk(32'(core_reset_n), 32'h0);
            bsc_board_i.release_pin();
            rd(`BSC_OFS_STATUS, 32'(v), `BSC_RESP_OKAY);
            chk_out(v);
            chk(32'(pcm), 32'(v[3:1]));
            chk(32'(presc), 32'(exp_presc(v[8])));
            // straps flipped after capture must leave everything alone
            bsc_board_i.wiggle(~v);
            repeat (12) @(posedge aclk);
            rd(`BSC_OFS_STATUS, 32'(v), `BSC_RESP_OKAY);
            chk_out(v);
            wr(`BSC_OFS_STATUS, 32'hFFFFFFFF, `BSC_RESP_OKAY);
            rd(`BSC_OFS_STATUS, 32'(v), `BSC_RESP_OKAY);
            rd(`BSC_OFS_RUNSTS, v[17] ? 32'h1 : 32'h2,
               `BSC_RESP_OKAY);
            chk(32'(core_reset_n), 32'(!v[17]));
            chk(32'(mben && sben), 32'h1);
            lf = lfsr(lf);
            wr(`BSC_OFS_PCLK, 32'(lf[2:0]), `BSC_RESP_OKAY);
            rd(`BSC_OFS_PCLK, 32'(lf[2:0]), `BSC_RESP_OKAY);
            chk(32'(pcm), 32'(lf[2:0]));
            wr(`BSC_OFS_BUSCTL, 32'(lf[15:8]), `BSC_RESP_OKAY);
            chk(32'(presc), 32'(lf[15:8]));
            chk_out(v);
            if (!v[17]) begin
                bsc_board_i.load_error();
                na = 0;
                repeat (5) begin
                    @(posedge aclk);
                    na += int'(abort_o === 1'b1);
                end
                chk(32'(na), 32'h1);
                rd(`BSC_OFS_SWITCH_CONTROL_REG, 32'h1, `BSC_RESP_OKAY);
                rd(`BSC_OFS_RUNSTS, 32'h1, `BSC_RESP_OKAY);
            end
            wr(`BSC_OFS_SWITCH_CONTROL_REG, 32'h0, `BSC_RESP_OKAY);
            repeat (2) @(posedge aclk);
            rd(`BSC_OFS_RUNSTS, 32'h2, `BSC_RESP_OKAY);
            chk(32'(core_reset_n), 32'h1);
        end
        // an unmapped place answers with an error and reads as zero
        rd(8'h20, 32'h0, `BSC_RESP_SLVERR);
        wr(8'h20, 32'h1, `BSC_RESP_SLVERR);
        // bus reset with the pin already high: capture follows the sync
        v = ~v;
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        chk(32'(core_reset_n), 32'h0);
        repeat (10) @(posedge aclk);
        rd(`BSC_OFS_STATUS, 32'(v), `BSC_RESP_OKAY);
        chk_out(v);
        chk(32'(pcm), 32'(v[3:1]));
        chk(32'(core_reset_n), 32'(!v[17]));
        // software may halt a running device by setting the hold bit
        wr(`BSC_OFS_SWITCH_CONTROL_REG, 32'h1, `BSC_RESP_OKAY);
        rd(`BSC_OFS_RUNSTS, 32'h1, `BSC_RESP_OKAY);
        chk(32'(core_reset_n), 32'h0);
        end_of_test();
    end
endmodule
`default_nettype wire
